/* File: rtl/sar_bit_clock.v */
`timescale 1ns/10ps
`include "sar_sequencer_defines.vh"

// ==========================================================
// gated bit clock: divides ref clock, runs only while enabled
module sar_bit_clock #(
	parameter DIV = `SAR_DIV_DEFAULT
)(
	input  wire ref_clk_i,
	input  wire rst_n_i,
	input  wire run_i,
	output reg  tick_o,
	output reg  gclk_o
);

	reg [`SAR_DIV_W-1:0] cnt_q;

	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q  <= `SAR_ZERO_DIV;
			tick_o <= 1'b0;
			gclk_o <= 1'b0;
		end
		else if (!run_i)
		begin
			cnt_q  <= `SAR_ZERO_DIV;
			tick_o <= 1'b0;
			gclk_o <= 1'b0;
		end
		else
		begin
			tick_o <= (cnt_q == DIV - 1);
			if (cnt_q == DIV - 1)
				cnt_q <= `SAR_ZERO_DIV;
			else
				cnt_q <= cnt_q + `SAR_ONE_DIV;
			gclk_o <= (cnt_q < DIV / 2);
		end
	end

endmodule // sar_bit_clock

/* File: rtl/sar_conversion_sequencer.v */
// Summary of operation
// - host pulses convert command; device converts sampled level to 16-bit result.
// - one 16-bit register drives result outputs and feedback dac inputs.
// - bits are tried one at a time, msb first, lsb last.
// - each trial bit is kept or cleared by comparator at period end.
// - result is complementary: straight binary unipolar, offset binary bipolar.
// - early-termination input ends sequence after the selected bit count.
// - status rises on convert command and stays high while converting.
// - trailing command edge initialises register, counters and clock inhibit.
// - gated clock runs one cycle per selected bit, 16 at most, while busy, then held low.
// - status clears after final decision; result valid on falling status.
`timescale 1ns/10ps
`include "sar_sequencer_defines.vh"

module sar_conversion_sequencer #(
	parameter DIV = `SAR_DIV_DEFAULT
)(
	input  wire                  ref_clk_i,
	input  wire                  reset_n_i,
	input  wire                  convert_i,
	input  wire                  comp_i,
	input  wire [`SAR_IDX_W-1:0] bits_sel_i,
	output reg  [`SAR_WIDTH-1:0] result_o,
	output reg  [`SAR_WIDTH-1:0] dac_o,
	output reg                   status_o,
	output reg                   clk_out_o
);

	// ==========================================================
	// reset release
	reg rst_a_q;
	reg rst_b_q;

	always @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_a_q <= 1'b0;
			rst_b_q <= 1'b0;
		end
		else
		begin
			rst_a_q <= 1'b1;
			rst_b_q <= rst_a_q;
		end
	end

	// ==========================================================
	// pin synchronisers, three stages
	reg [2:0] conv_s_q;
	reg [2:0] comp_s_q;
	reg       conv_q;
	reg       comp_q;

	always @(posedge ref_clk_i or negedge rst_b_q)
	begin
		if (!rst_b_q)
		begin
			conv_s_q <= 3'h0;
			comp_s_q <= 3'h0;
			conv_q   <= 1'b0;
			comp_q   <= 1'b0;
		end
		else
		begin
			conv_s_q <= {conv_s_q[1:0], convert_i};
			comp_s_q <= {comp_s_q[1:0], comp_i};
			if (conv_s_q[1] == conv_s_q[2])
				conv_q <= conv_s_q[2];
			if (comp_s_q[1] == comp_s_q[2])
				comp_q <= comp_s_q[2];
		end
	end

	// ==========================================================
	// resolution pins, three stages
	reg [`SAR_IDX_W-1:0] sel_s1_q;
	reg [`SAR_IDX_W-1:0] sel_s2_q;
	reg [`SAR_IDX_W-1:0] sel_s3_q;
	reg [`SAR_IDX_W-1:0] sel_q;

	// whole word moves only once the last two stages agree
	always @(posedge ref_clk_i or negedge rst_b_q)
	begin
		if (!rst_b_q)
		begin
			sel_s1_q <= `SAR_ZERO_IDX;
			sel_s2_q <= `SAR_ZERO_IDX;
			sel_s3_q <= `SAR_ZERO_IDX;
			sel_q    <= `SAR_BITS_FULL;
		end
		else
		begin
			sel_s1_q <= bits_sel_i;
			sel_s2_q <= sel_s1_q;
			sel_s3_q <= sel_s2_q;
			if (sel_s2_q == sel_s3_q)
				sel_q <= sel_s3_q;
		end
	end

	// ==========================================================
	// bit clock
	wire tick;
	wire gclk;
	reg  run_q;

	sar_bit_clock #(
		.DIV (DIV)
	) u_clk (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_b_q),
		.run_i     (run_q),
		.tick_o    (tick),
		.gclk_o    (gclk)
	);

	// ==========================================================
	// sequencer
	localparam ST_IDLE = 2'b00;
	localparam ST_ARM  = 2'b01;
	localparam ST_CONV = 2'b10;
	localparam ST_DONE = 2'b11;

	reg [1:0]            st_q;
	reg [`SAR_WIDTH-1:0] sar_q;
	reg [`SAR_IDX_W-1:0] idx_q;
	reg [`SAR_IDX_W-1:0] nbits_q;
	reg [`SAR_IDX_W-1:0] cyc_q;

	function [`SAR_IDX_W-1:0] clamp_bits;
		input [`SAR_IDX_W-1:0] b;
		begin
			if (b < `SAR_BITS_MIN || b > `SAR_BITS_FULL)
				clamp_bits = `SAR_BITS_FULL;
			else
				clamp_bits = b;
		end
	endfunction

	// bit index counts from msb (0) downward
	function [`SAR_WIDTH-1:0] onehot;
		input [`SAR_IDX_W-1:0] i;
		begin
			onehot = {1'b1, {(`SAR_WIDTH-1){1'b0}}} >> i;
		end
	endfunction

	always @(posedge ref_clk_i or negedge rst_b_q)
	begin
		if (!rst_b_q)
		begin
			st_q     <= ST_IDLE;
			sar_q    <= `SAR_ZERO_WORD;
			idx_q    <= `SAR_ZERO_IDX;
			nbits_q  <= `SAR_BITS_FULL;
			cyc_q    <= `SAR_ZERO_IDX;
			run_q    <= 1'b0;
			status_o <= 1'b0;
		end
		else
		begin
			case (st_q)
			ST_IDLE:
			begin
				if (conv_q)
				begin
					status_o <= 1'b1;
					st_q     <= ST_ARM;
				end
			end
			ST_ARM:
			begin
				if (!conv_q)
				begin
					// trailing edge: init register, counters and inhibit
					sar_q   <= `SAR_INIT_WORD;
					idx_q   <= `SAR_ZERO_IDX;
					cyc_q   <= `SAR_ZERO_IDX;
					nbits_q <= clamp_bits(sel_q);
					run_q   <= 1'b1;
					st_q    <= ST_CONV;
				end
			end
			ST_CONV:
			begin
				if (tick)
				begin
					cyc_q <= cyc_q + 5'd1;
					// decide current bit, trial next bit
					if (idx_q < nbits_q)
					begin
						sar_q <= (sar_q & ~(onehot(idx_q + 5'd1)))
							| (comp_q ? `SAR_ZERO_WORD : onehot(idx_q));
						idx_q <= idx_q + 5'd1;
					end
					if (cyc_q + 5'd1 >= `SAR_GATED_CYCLES || idx_q + 5'd1 >= nbits_q)
					begin
						run_q <= 1'b0;
						st_q  <= ST_DONE;
					end
				end
			end
			ST_DONE:
			begin
				// drop status only once the pins already show the final word
				if (result_o == sar_q)
				begin
					status_o <= 1'b0;
					st_q     <= ST_IDLE;
				end
			end
			default:
				st_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// outputs: one register feeds result pins and dac
	always @(posedge ref_clk_i or negedge rst_b_q)
	begin
		if (!rst_b_q)
		begin
			result_o  <= `SAR_ZERO_WORD;
			dac_o     <= `SAR_ZERO_WORD;
			clk_out_o <= 1'b0;
		end
		else
		begin
			result_o  <= sar_q;
			dac_o     <= sar_q;
			clk_out_o <= gclk & run_q;
		end
	end

endmodule // sar_conversion_sequencer

/* File: rtl/sar_sequencer_defines.vh */
`ifndef SAR_SEQUENCER_DEFINES_VH
`define SAR_SEQUENCER_DEFINES_VH

// ==========================================================
// widths and counts
`define SAR_WIDTH        16
`define SAR_IDX_W        5
`define SAR_BITS_FULL    5'd16
`define SAR_BITS_MIN     5'd1
`define SAR_GATED_CYCLES 5'd17
`define SAR_DIV_DEFAULT  120
`define SAR_DIV_W        8

// ==========================================================
// reset and initial values
`define SAR_ZERO_WORD    16'h0000
`define SAR_INIT_WORD    16'h7fff
`define SAR_ZERO_IDX     5'd0
`define SAR_ZERO_DIV     8'h00
`define SAR_ONE_DIV      8'h01

`endif

/* File: testbench/sar_conversion_sequencer_asserts.sv */
`timescale 1ns/10ps
// ==========
// port checks
module sar_conversion_sequencer_asserts(
	input wire        ref_clk_i,
	input wire        reset_n_i,
	input wire        convert_i,
	input wire [15:0] result_o,
	input wire [15:0] dac_o,
	input wire        status_o,
	input wire        clk_out_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	chk_dac_mirror: assert property
		(!status_o && $past(!status_o) |-> result_o == dac_o) else $error("dac differs");
	chk_clk_parked: assert property
		(!status_o && $past(!status_o) |-> !clk_out_o) else $error("clock not low");
	chk_status_rise: assert property
		($rose(convert_i) |-> ##[1:8] status_o) else $error("no busy");
	chk_init_word: assert property
		($rose(status_o) ##[0:6] $fell(convert_i) |-> ##[1:8] dac_o == 16'h7fff)
		else $error("no init word");
	chk_busy_min: assert property
		($rose(status_o) |-> status_o[*8]) else $error("busy too short");
	chk_done_bound: assert property
		($rose(status_o) |-> ##[8:200] !status_o) else $error("busy too long");
	chk_result_hold: assert property
		(!status_o && $past(!status_o) |-> $stable(result_o)) else $error("result moved");
	chk_clk_gated: assert property
		($rose(clk_out_o) |-> $past(status_o)) else $error("clock while idle");
	cover property ($rose(status_o));
	cover property ($fell(status_o));
	cover property ($rose(clk_out_o));
endmodule // sar_conversion_sequencer_asserts

bind sar_conversion_sequencer sar_conversion_sequencer_asserts u_chk(
	.ref_clk_i, .reset_n_i, .convert_i, .result_o, .dac_o, .status_o, .clk_out_o);

/* File: testbench/sar_conversion_sequencer_tb_top.sv */
`timescale 1ns/10ps
module sar_conversion_sequencer_tb_top;
	logic        ref_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [4:0]  bits_sel_i = 5'h10;
	logic        convert_i;
	logic        comp_i;
	wire  [15:0] result_o;
	wire  [15:0] dac_o;
	wire         status_o;
	wire         clk_out_o;
	integer      bad_count = 0;
	integer      comparisons = 0;
	// bit period must cover the comparator path through its synchroniser
	localparam int DIV_SIM = 8;
	sar_conversion_sequencer #(.DIV(DIV_SIM)) uut(.ref_clk_i, .reset_n_i, .convert_i, .comp_i,
		.bits_sel_i, .result_o, .dac_o, .status_o, .clk_out_o);
	sar_host_model host(.clk_i(ref_clk_i), .dac_i(dac_o), .convert_o(convert_i),
		.comp_o(comp_i));
	task cmp(input logic [15:0] got, exp);
	begin
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task conv(input logic [15:0] v, input logic [4:0] s);
		integer n;
		integer k;
		logic [15:0] e;
	begin
		n = (s == 5'h00 || s > 5'h10) ? 16 : s;
		// undecided bits read binary 0, except the next trial bit left set
		e = (v & (16'hffff << (16 - n))) | (16'h8000 >> n);
		bits_sel_i = s;
		host.start(v);
		k = 0;
		while (status_o === 1'b1 && k < 200)
		begin
			@(negedge ref_clk_i);
			k++;
		end
		cmp(result_o, ~e);
		cmp({~result_o[15], result_o[14:0]}, ~(e ^ 16'h8000));
		cmp({15'h0000, k >= DIV_SIM * n && k <= DIV_SIM * n + 8}, 16'h0001);
	end
	endtask
	task test_codes;
	begin
		conv(16'h677a, 5'h10);
		conv(16'h0000, 5'h10);
		conv(16'hb3c5, 5'h01);
		conv(16'hb3c5, 5'h0a);
		conv(16'hb3c5, 5'h00);
		conv(16'h4c3a, 5'h1f);
	end
	endtask
	// a second command while busy is ignored
	task test_busy;
	begin
		fork
			conv(16'h1234, 5'h10);
			begin
				repeat (20) @(negedge ref_clk_i);
				host.start(16'h1234);
			end
		join
		cmp({15'h0000, status_o}, 16'h0000);
	end
	endtask
	// reset in mid-conversion returns every output to zero
	task test_reset;
	begin
		bits_sel_i = 5'h10;
		host.start(16'h5a5a);
		repeat (20) @(negedge ref_clk_i);
		reset_n_i = 1'b0;
		@(negedge ref_clk_i);
		cmp({12'h000, status_o, clk_out_o, |result_o, |dac_o}, 16'h0000);
		reset_n_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		conv(16'h5a5a, 5'h10);
	end
	endtask
	task stop_test;
	begin
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	initial
	begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	initial
	begin
		repeat (8) @(negedge ref_clk_i);
		reset_n_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		test_codes;
		test_busy;
		test_reset;
		stop_test;
	end
	initial
	begin
		#12000;
		bad_count++;
		stop_test;
	end
endmodule // sar_conversion_sequencer_tb_top

/* File: testbench/sar_host_model.sv */
`timescale 1ns/10ps
// ==========
// host and comparator
module sar_host_model(
	input  wire        clk_i,
	input  wire [15:0] dac_i,
	output logic       convert_o,
	output logic       comp_o
);
	logic [15:0] level_q = 16'h0000;
	initial
	begin
		convert_o = 1'b0;
		comp_o = 1'b0;
	end
	// trial code is the dac word inverted; comparator high keeps the trial bit
	always @(negedge clk_i) comp_o <= level_q >= ~dac_i;
	task start(input logic [15:0] v);
	begin
		level_q = v;
		convert_o = 1'b1;
		repeat (6) @(negedge clk_i);
		convert_o = 1'b0;
	end
	endtask
endmodule // sar_host_model
